// *** logic/rsd_defines.svh ***
`ifndef RSD_DEFINES_SVH
`define RSD_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define RSD_ADDR_RX_STATUS 8'h08
`define RSD_ADDR_RX_DATA_A 8'h09
`define RSD_ADDR_RX_MASK_A 8'h0A
`define RSD_ADDR_RX_DATA_B 8'h0B
`define RSD_ADDR_RX_MASK_B 8'h0C
`define RSD_ADDR_TX_ENABLE 8'h0D
`define RSD_ADDR_TX_STATUS 8'h0E
`define RSD_ADDR_TX_DATA   8'h0F
`define RSD_ADDR_TX_MASK   8'h10

// ****************************************************************
// field positions, reset values, counts
// ****************************************************************
`define RSD_RXE_FULL       0
`define RSD_RXE_EOF        1
`define RSD_RXE_OVF        2
`define RSD_RXE_UNF        3
`define RSD_RXE_B_LSB      4
`define RSD_RXE_B_MSB      7
`define RSD_RXE_A_MSB      3
`define RSD_TX_FLAG_MSB    3
`define RSD_RST_BYTE       8'h00
`define RSD_ZERO_NIBBLE    4'h0
`define RSD_LAST_BIT       3'h7
`define RSD_FIRST_BIT      3'h0
`define RSD_BIT_STEP       3'h1
`define RSD_BUF_DEPTH      2

`endif

// *** logic/rsd_pkg.sv ***
// ****************************************************************
// shared types
// ****************************************************************
package rsd_pkg;

    typedef enum logic {
        RSD_IDLE = 1'b0,
        RSD_RECV = 1'b1
    } rsd_phase_e;

    // one bit time from a correlator channel
    typedef struct packed {
        logic tick;
        logic valid;
        logic value;
    } rsd_rx_bit_s;

    // decoded access from the serial control port
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsd_reg_req_s;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] mask;
    } rsd_tx_word_s;

    typedef struct packed {
        rsd_phase_e phase;
        logic [2:0] cnt;
        logic [2:0] gap;
        logic [7:0] shift_data;
        logic [7:0] shift_mask;
        logic [7:0] data;
        logic [7:0] mask;
        logic       held;
        logic       full;
        logic       eof;
        logic       ovf;
        logic       unf;
        logic       all_valid;
    } rsd_rx_ch_s;

    typedef struct packed {
        logic unf;
        logic ovf;
        logic done;
        logic empty;
    } rsd_tx_flags_s;

    typedef struct packed {
        rsd_rx_ch_s    rx_a;
        rsd_rx_ch_s    rx_b;
        rsd_tx_flags_s tx;
        logic [7:0]    tx_ie;
        rsd_tx_word_s  hold;
        logic          hold_full;
        logic          sent_any;
        logic [7:0]    rdata;
        logic          irq;
    } rsd_core_s;

endpackage : rsd_pkg

// *** logic/rsd_buf2.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// small ring buffer, stalls the writer when full
// ****************************************************************
module rsd_buf2 #(
    parameter int W     = 16,
    parameter int DEPTH = 2
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // pointers wrap naturally, so only powers of two work
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("rsd_buf2: DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wptr;
        logic [AW-1:0]           rptr;
        logic [AW:0]             count;
    } rsd_buf_s;

    rsd_buf_s st;
    rsd_buf_s next_st;
    logic     push;
    logic     pop;

    // handshakes straight from the occupancy count
    assign in_ready  = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data  = st.mem[st.rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = in_data;
            next_st.wptr         = st.wptr + AW'(1);
        end
        if (pop) begin
            next_st.rptr = st.rptr + AW'(1);
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    chk_buf_no_overfill: assert property (@(posedge ref_clk) disable iff (!nrst)
        st.count <= (AW+1)'(DEPTH))
        else $error("buffer holds more words than its depth");

endmodule : rsd_buf2
`default_nettype wire

// *** logic/rsd_serdes_regs.sv ***
// What this block does
// [RQ1] channel A full raises the interrupt only while its enable bit is set
// [RQ2] full arises on every load: complete byte or partial byte at end of frame
// [RQ3] each load sets the all-valid flag only when all eight bits are valid
// [RQ4] flow violation on load before read, or on reading an empty data register
// [RQ5] end of frame after the set number of bit times without a valid bit
// [RQ6] full flag is set whenever a channel's data register is filled
// [RQ7] reading receive status clears flow violation, end of frame and full flags
// [RQ8] flags set and readable regardless of the interrupt enables
// [RQ9] receive status reads zero outside receive mode, transmit status outside transmit
// [RQ10] first received bit lands in bit 0, later bits ascend to bit 7
// [RQ11] valid mask holds one for each valid data bit, zero elsewhere
// [RQ12] host may skip the valid mask when the all-valid flag is set
// [RQ13] host writes zero to the upper four transmit enable bits
// [RQ14] transmit underflow when the transmitter needs data and none waits
// [RQ15] transmit overflow when data is written before the previous byte moved on
// [RQ16] transmit done once the last byte went out and nothing more waits
// [RQ17] transmit empty when the data byte is taken into the transmit buffer
// [RQ18] reading transmit status clears underflow, overflow and done
// [RQ19] writing transmit data clears empty unless a byte moves on that cycle; it sets again when that byte moves on
// [RQ20] end of frame gap comes from three bits; zero fires at first invalid bit
// [RQ21] interrupt output is high while any enabled flag is pending; receive flags count only with rx_enable, transmit flags only with tx_enable
`timescale 1ns/100ps
`default_nettype none
`include "rsd_defines.svh"
module rsd_serdes_regs #(
    parameter int BUF_DEPTH = `RSD_BUF_DEPTH
) (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire rsd_pkg::rsd_reg_req_s reg_req,
    output logic [7:0]                reg_rdata,
    input  wire logic                 rx_enable,
    input  wire logic                 tx_enable,
    input  wire logic [2:0]           eof_length,
    input  wire logic [7:0]           rx_event_enable,
    input  wire rsd_pkg::rsd_rx_bit_s rx_a,
    input  wire rsd_pkg::rsd_rx_bit_s rx_b,
    output rsd_pkg::rsd_tx_word_s     tx_word,
    output logic                      tx_word_valid,
    input  wire logic                 tx_word_ready,
    input  wire logic                 tx_byte_sent,
    input  wire logic                 tx_needs_data,
    output logic                      irq
);
    // ****************************************************************
    // helpers
    // ****************************************************************

    // one bit time of one receive channel, plus host reads of it
    function automatic rsd_pkg::rsd_rx_ch_s rx_step(
        input rsd_pkg::rsd_rx_ch_s  cur,
        input rsd_pkg::rsd_rx_bit_s in,
        input logic [2:0]           eof_len,
        input logic                 rd_data,
        input logic                 rd_stat,
        input logic                 en
    );
        rsd_pkg::rsd_rx_ch_s nx;
        logic                load;
        logic [7:0]          d;
        logic [7:0]          m;
        nx   = cur;
        load = 1'b0;
        d    = cur.shift_data;
        m    = cur.shift_mask;
        // clears first so that a same-cycle event below wins
        if (rd_stat) begin
            nx.full = 1'b0; // [RQ7]
            nx.eof  = 1'b0;
            nx.ovf  = 1'b0;
            nx.unf  = 1'b0;
        end
        if (rd_data) begin
            if (cur.held) begin
                nx.held = 1'b0;
            end else begin
                nx.unf = 1'b1; // [RQ4]
            end
        end
        if (!en) begin
            // leaving receive mode drops any half-built byte
            nx.phase = rsd_pkg::RSD_IDLE;
            nx.cnt   = `RSD_FIRST_BIT;
            nx.gap   = `RSD_FIRST_BIT;
            d        = `RSD_RST_BYTE;
            m        = `RSD_RST_BYTE;
        end else if (in.tick) begin
            if (in.valid) begin
                d[cur.cnt] = in.value; // [RQ10]
                m[cur.cnt] = 1'b1; // [RQ11]
                nx.phase   = rsd_pkg::RSD_RECV;
                nx.gap     = `RSD_FIRST_BIT;
                load       = (cur.cnt == `RSD_LAST_BIT);
                nx.cnt     = 3'(cur.cnt + `RSD_BIT_STEP);
            end else if (cur.phase == rsd_pkg::RSD_RECV) begin
                if (cur.gap == eof_len) begin
                    nx.eof   = 1'b1; // [RQ5] [RQ20]
                    nx.phase = rsd_pkg::RSD_IDLE;
                    nx.gap   = `RSD_FIRST_BIT;
                    load     = (cur.cnt != `RSD_FIRST_BIT); // [RQ2]
                    nx.cnt   = `RSD_FIRST_BIT;
                end else begin
                    // a short gap keeps its slot, marked invalid
                    d[cur.cnt] = 1'b0;
                    m[cur.cnt] = 1'b0;
                    nx.gap     = 3'(cur.gap + `RSD_BIT_STEP);
                    load       = (cur.cnt == `RSD_LAST_BIT);
                    nx.cnt     = 3'(cur.cnt + `RSD_BIT_STEP);
                end
            end
        end
        if (load) begin
            nx.data      = d;
            nx.mask      = m;
            nx.full      = 1'b1; // [RQ2] [RQ6]
            nx.all_valid = &m; // [RQ3]
            if (cur.held && !rd_data) begin
                nx.ovf = 1'b1; // [RQ4]
            end
            nx.held = 1'b1;
            d       = `RSD_RST_BYTE;
            m       = `RSD_RST_BYTE;
        end
        nx.shift_data = d;
        nx.shift_mask = m;
        return nx;
    endfunction : rx_step

    // status nibble of one channel: all-valid, flow violation, eof, full
    function automatic logic [3:0] rx_nibble(input rsd_pkg::rsd_rx_ch_s ch);
        return {ch.all_valid, ch.ovf | ch.unf, ch.eof, ch.full};
    endfunction : rx_nibble

    // pending causes of one channel against its four enable bits
    function automatic logic rx_pending(input rsd_pkg::rsd_rx_ch_s ch, input logic [3:0] en);
        return (ch.full && en[`RSD_RXE_FULL]) || (ch.eof && en[`RSD_RXE_EOF])
            || (ch.ovf && en[`RSD_RXE_OVF]) || (ch.unf && en[`RSD_RXE_UNF]);
    endfunction : rx_pending

    // ****************************************************************
    // state and decode
    // ****************************************************************
    rsd_pkg::rsd_core_s    st;
    rsd_pkg::rsd_core_s    next_st;
    rsd_pkg::rsd_tx_word_s buf_word;
    logic                  buf_in_ready;
    logic                  move;
    logic                  rd_rx_stat;
    logic                  rd_tx_stat;
    logic                  rd_data_a;
    logic                  rd_data_b;
    logic                  wr_tx_data;
    logic [3:0]            tx_nibble;

    // host access strobes
    assign rd_rx_stat = reg_req.rd && (reg_req.addr == `RSD_ADDR_RX_STATUS);
    assign rd_tx_stat = reg_req.rd && (reg_req.addr == `RSD_ADDR_TX_STATUS);
    assign rd_data_a  = reg_req.rd && (reg_req.addr == `RSD_ADDR_RX_DATA_A);
    assign rd_data_b  = reg_req.rd && (reg_req.addr == `RSD_ADDR_RX_DATA_B);
    assign wr_tx_data = reg_req.wr && (reg_req.addr == `RSD_ADDR_TX_DATA);
    assign move       = st.hold_full && buf_in_ready;
    assign tx_nibble  = {st.tx.unf, st.tx.ovf, st.tx.done, st.tx.empty};

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        // both receive channels share one step function
        next_st.rx_a = rx_step(st.rx_a, rx_a, eof_length, rd_data_a, rd_rx_stat, rx_enable);
        next_st.rx_b = rx_step(st.rx_b, rx_b, eof_length, rd_data_b, rd_rx_stat, rx_enable);

        // transmit: clears before sets, so an event in the read cycle survives
        if (rd_tx_stat) begin
            next_st.tx.unf  = 1'b0; // [RQ18]
            next_st.tx.ovf  = 1'b0;
            next_st.tx.done = 1'b0;
        end
        if (wr_tx_data) begin
            next_st.tx.empty = 1'b0; // [RQ19]
            next_st.hold.data = reg_req.wdata;
            next_st.hold_full = 1'b1;
            if (st.hold_full && !move) begin
                next_st.tx.ovf = 1'b1; // [RQ15]
            end
        end else if (move) begin
            next_st.hold_full = 1'b0;
        end
        if (move) begin
            next_st.tx.empty = 1'b1; // [RQ17] [RQ19]
        end
        if (reg_req.wr && reg_req.addr == `RSD_ADDR_TX_MASK) begin
            next_st.hold.mask = reg_req.wdata;
        end
        if (reg_req.wr && reg_req.addr == `RSD_ADDR_TX_ENABLE) begin
            next_st.tx_ie = reg_req.wdata; // stored whole; upper bits are host's to zero
        end
        if (tx_byte_sent) begin
            next_st.sent_any = 1'b1;
            if (!tx_word_valid && !st.hold_full) begin
                next_st.tx.done = 1'b1; // [RQ16]
            end
        end
        if (tx_needs_data && st.sent_any && !tx_word_valid) begin
            next_st.tx.unf = 1'b1; // [RQ14]
        end

        // registered read data; flags read as they stood before the clear
        if (reg_req.rd) begin
            case (reg_req.addr)
                `RSD_ADDR_RX_STATUS: next_st.rdata = rx_enable ?
                    {rx_nibble(st.rx_b), rx_nibble(st.rx_a)} : `RSD_RST_BYTE; // [RQ8] [RQ9]
                `RSD_ADDR_RX_DATA_A: next_st.rdata = st.rx_a.data;
                `RSD_ADDR_RX_MASK_A: next_st.rdata = st.rx_a.mask;
                `RSD_ADDR_RX_DATA_B: next_st.rdata = st.rx_b.data;
                `RSD_ADDR_RX_MASK_B: next_st.rdata = st.rx_b.mask;
                `RSD_ADDR_TX_ENABLE: next_st.rdata = st.tx_ie;
                `RSD_ADDR_TX_STATUS: next_st.rdata = tx_enable ?
                    {`RSD_ZERO_NIBBLE, tx_nibble} : `RSD_RST_BYTE; // [RQ9]
                default:             next_st.rdata = `RSD_RST_BYTE;
            endcase
        end

        // interrupt follows the flags that will stand next cycle
        next_st.irq = (rx_enable
                && (rx_pending(next_st.rx_a, rx_event_enable[`RSD_RXE_A_MSB:0]) // [RQ1]
                || rx_pending(next_st.rx_b, rx_event_enable[`RSD_RXE_B_MSB:`RSD_RXE_B_LSB])))
            || (tx_enable && |({next_st.tx.unf, next_st.tx.ovf, next_st.tx.done, next_st.tx.empty}
                & st.tx_ie[`RSD_TX_FLAG_MSB:0])); // [RQ21]
    end

    // single state register, synchronous reset to all zero
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // transmit buffer between holding register and transmitter
    // ****************************************************************
    // two entries let the transmitter stall without dropping a byte
    rsd_buf2 #(
        .W     ($bits(rsd_pkg::rsd_tx_word_s)),
        .DEPTH (BUF_DEPTH)
    ) u_tx_buf (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_valid  (st.hold_full),
        .in_ready  (buf_in_ready),
        .in_data   (st.hold),
        .out_valid (tx_word_valid),
        .out_ready (tx_word_ready),
        .out_data  (buf_word)
    );

    assign tx_word   = buf_word;
    assign reg_rdata = st.rdata;
    assign irq       = st.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_last_valid_a;
        rx_enable && rx_a.tick && rx_a.valid && st.rx_a.cnt == `RSD_LAST_BIT;
    endsequence

    sequence s_tx_write;
        wr_tx_data && !move;
    endsequence

    sequence s_tx_move;
        move && !wr_tx_data;
    endsequence

    chk_full_irq_a: assert property ( // [RQ1]
        st.rx_a.full && $past(rx_enable && rx_event_enable[`RSD_RXE_FULL]) |-> irq)
        else $error("enabled full A did not raise the interrupt");

    chk_load_sets_full: assert property ( // [RQ2]
        s_last_valid_a |=> st.rx_a.full && st.rx_a.held)
        else $error("byte load did not set full A");

    chk_all_valid_flag: assert property ( // [RQ3]
        s_last_valid_a and (st.rx_a.shift_mask[6:0] == 7'h7F) |=> st.rx_a.all_valid)
        else $error("all-valid A not set on a fully valid byte");

    chk_overflow_flag: assert property ( // [RQ4]
        s_last_valid_a and (st.rx_a.held && !rd_data_a) |=> st.rx_a.ovf)
        else $error("overflow A not flagged");

    chk_underflow_flag: assert property ( // [RQ4]
        rd_data_a && !st.rx_a.held |=> st.rx_a.unf)
        else $error("underflow A not flagged");

    chk_eof_gap: assert property ( // [RQ5]
        rx_enable && rx_a.tick && !rx_a.valid && st.rx_a.phase == rsd_pkg::RSD_RECV
            && st.rx_a.gap == eof_length |=> st.rx_a.eof && st.rx_a.phase == rsd_pkg::RSD_IDLE)
        else $error("end of frame A missed");

    chk_status_clear: assert property ( // [RQ7]
        rd_rx_stat && !rx_a.tick && !rd_data_a |=> !st.rx_a.full && !st.rx_a.eof && !st.rx_a.ovf)
        else $error("status read did not clear channel A flags");

    chk_rx_zero_off: assert property ( // [RQ9]
        rd_rx_stat && !rx_enable |=> reg_rdata == `RSD_RST_BYTE)
        else $error("receive status not zero outside receive mode");

    chk_bit_order: assert property ( // [RQ10]
        rx_enable && rx_a.tick && rx_a.valid && st.rx_a.cnt == `RSD_FIRST_BIT
            |=> st.rx_a.shift_data[0] == $past(rx_a.value) && st.rx_a.cnt == `RSD_BIT_STEP)
        else $error("first received bit not in bit 0");

    chk_tx_overflow: assert property ( // [RQ15]
        s_tx_write ##1 !move ##1 s_tx_write |=> st.tx.ovf)
        else $error("second write before move did not flag overflow");

    chk_empty_cycle: assert property ( // [RQ19]
        s_tx_write ##1 (s_tx_move and !rd_tx_stat) |=> st.tx.empty ##0 !st.hold_full)
        else $error("empty not set again after the byte moved");

    chk_tx_underflow: assert property ( // [RQ14]
        tx_needs_data && st.sent_any && !tx_word_valid |=> st.tx.unf)
        else $error("transmit underflow not flagged");

    chk_irq_idle: assert property ( // [RQ21]
        !(|(tx_nibble & st.tx_ie[`RSD_TX_FLAG_MSB:0]))
            && !rx_pending(st.rx_a, rx_event_enable[`RSD_RXE_A_MSB:`RSD_RXE_FULL])
            && !rx_pending(st.rx_b, rx_event_enable[`RSD_RXE_B_MSB:`RSD_RXE_B_LSB]) && $stable(rx_event_enable)
            && $stable(st.tx_ie) |-> !irq)
        else $error("interrupt high with nothing enabled pending");

endmodule : rsd_serdes_regs
`default_nettype wire

// *** verification/rsd_tx_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ********
// transmitter model at the far side of the word buffer
// ********
module rsd_tx_model (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire logic                  stall,
    input  wire rsd_pkg::rsd_tx_word_s tx_word,
    input  wire logic                  tx_word_valid,
    output logic                       tx_word_ready,
    output logic                       tx_byte_sent,
    output logic                       tx_needs_data,
    output rsd_pkg::rsd_tx_word_s      last_word,
    output logic [7:0]                 taken
);
    logic [3:0] busy;

    // only idle and unstalled takes a word, so a stall backs words up in the buffer
    assign tx_word_ready = !stall && (busy == 4'h0);

    // busy ten cycles per byte; finished pulse, then a request for the next byte
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            busy          <= 4'h0;
            taken         <= 8'h00;
            last_word     <= '0;
            tx_byte_sent  <= 1'b0;
            tx_needs_data <= 1'b0;
        end else begin
            tx_byte_sent  <= (busy == 4'h2);
            tx_needs_data <= (busy == 4'h1);
            if (tx_word_valid && tx_word_ready) begin
                busy      <= 4'hA;
                last_word <= tx_word;
                taken     <= taken + 8'h01;
            end else if (busy != 4'h0) begin
                busy <= busy - 4'h1;
            end
        end
    end
endmodule : rsd_tx_model
`default_nettype wire

// *** verification/rsd_serdes_regs_test.sv ***
`timescale 1ns/100ps
`default_nettype none
// ********
// register bench for the serdes buffer block
// ********
module rsd_serdes_regs_test;
    logic                  ref_clk;
    logic                  nrst;
    rsd_pkg::rsd_reg_req_s req;
    logic [7:0]            rdata;
    logic                  rx_enable;
    logic                  tx_enable;
    logic [2:0]            eof_length;
    logic [7:0]            rx_ie;
    rsd_pkg::rsd_rx_bit_s  rx_a;
    rsd_pkg::rsd_rx_bit_s  rx_b;
    rsd_pkg::rsd_tx_word_s tx_word;
    rsd_pkg::rsd_tx_word_s last_word;
    logic                  tx_valid;
    logic                  tx_ready;
    logic                  sent;
    logic                  need;
    logic                  irq;
    logic                  stall;
    logic [7:0]            taken;
    int                    error_cnt;
    int                    comparisons;
    int                    cycles;

    rsd_serdes_regs i_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_req(req), .reg_rdata(rdata),
        .rx_enable(rx_enable), .tx_enable(tx_enable), .eof_length(eof_length),
        .rx_event_enable(rx_ie), .rx_a(rx_a), .rx_b(rx_b), .tx_word(tx_word),
        .tx_word_valid(tx_valid), .tx_word_ready(tx_ready), .tx_byte_sent(sent),
        .tx_needs_data(need), .irq(irq));
    rsd_tx_model i_tx (.ref_clk(ref_clk), .nrst(nrst), .stall(stall), .tx_word(tx_word),
        .tx_word_valid(tx_valid), .tx_word_ready(tx_ready), .tx_byte_sent(sent),
        .tx_needs_data(need), .last_word(last_word), .taken(taken));

    // ********
    // clock, timeout and verdict
    // ********
    always #25 ref_clk = !ref_clk;

    // the whole run needs well under a thousand cycles; a hang stops here
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : check

    // ********
    // register port and receive bit drivers
    // ********
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        req = '{1'b0, 1'b1, a, d};
        @(negedge ref_clk);
        req = '0;
    endtask : wr

    // read data holds until the next read, so one spare cycle is harmless
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        req = '{1'b1, 1'b0, a, 8'h00};
        @(negedge ref_clk);
        req = '0;
        @(negedge ref_clk);
        check(rdata, exp);
    endtask : rd

    // one slot per cycle; invalid slots carry 0 so data expectations stay fixed
    task automatic bits(input logic ch, input logic [7:0] d, input logic [7:0] m, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge ref_clk);
            if (ch) rx_b = '{1'b1, m[k], d[k] & m[k]};
            else rx_a = '{1'b1, m[k], d[k] & m[k]};
        end
        @(negedge ref_clk);
        rx_a = '0;
        rx_b = '0;
    endtask : bits

    // ********
    // main sequence
    // ********
    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        req = '0;
        rx_enable = 1'b1;
        tx_enable = 1'b1;
        eof_length = 3'h0;
        rx_ie = 8'h00;
        rx_a = '0;
        rx_b = '0;
        stall = 1'b1;
        error_cnt = 0;
        comparisons = 0;
        cycles = 0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'b1;
        // reset values, unmapped read, enable read back, read-only write ignored
        for (int a = 8; a < 15; a++) rd(8'(a), 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h0D, 8'h06);
        rd(8'h0D, 8'h06);
        wr(8'h0D, 8'h00);
        wr(8'h09, 8'hFF);
        rd(8'h09, 8'h00);
        rd(8'h08, 8'h44);
        rd(8'h08, 8'h00);
        // full byte with its interrupt on, then a second load before the data register is read
        rx_ie = 8'h01;
        bits(1'b0, 8'h3C, 8'hFF, 8);
        repeat (2) @(negedge ref_clk);
        check({7'h00, irq}, 8'h01);
        rd(8'h0A, 8'hFF);
        bits(1'b0, 8'h5A, 8'hFF, 8);
        rd(8'h08, 8'h0D);
        check({7'h00, irq}, 8'h00);
        rd(8'h09, 8'h5A);
        rx_ie = 8'h00;
        // partial byte on B ended by a gap of three invalid slots
        eof_length = 3'h2;
        bits(1'b1, 8'h0B, 8'h0F, 6);
        rd(8'h08, 8'h08);
        bits(1'b1, 8'h00, 8'h00, 1);
        rd(8'h08, 8'h38);
        rd(8'h0C, 8'h0F);
        rd(8'h0B, 8'h0B);
        // gap of zero on A, status masked outside receive mode
        eof_length = 3'h0;
        bits(1'b0, 8'h01, 8'h01, 2);
        check({7'h00, irq}, 8'h00);
        rx_enable = 1'b0;
        rd(8'h08, 8'h00);
        rx_enable = 1'b1;
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h01);
        // stalled transmitter: two words buffered, one held, one overflows
        wr(8'h10, 8'hFF);
        wr(8'h0F, 8'h11);
        wr(8'h0F, 8'h22);
        wr(8'h0F, 8'h33);
        wr(8'h0F, 8'h44);
        rd(8'h0E, 8'h04);
        wr(8'h0D, 8'h02);
        stall = 1'b0;
        for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge ref_clk);
        check({7'h00, irq}, 8'h01);
        check(taken, 8'h03);
        check(last_word.mask, 8'hFF);
        check(last_word.data, 8'h44);
        rd(8'h0E, 8'h0B);
        check({7'h00, irq}, 8'h00);
        tx_enable = 1'b0;
        rd(8'h0E, 8'h00);
        tx_enable = 1'b1;
        rd(8'h0E, 8'h01);
        conclude();
    end
endmodule : rsd_serdes_regs_test
`default_nettype wire
